// ### design/ofdfec_map.vh
`ifndef OFDFEC_MAP_VH
`define OFDFEC_MAP_VH

// register offsets
`define OFDFEC_REG_CTRL   4'h0
`define OFDFEC_REG_SYMS   4'h4
`define OFDFEC_REG_PAD    4'h8

// control register fields and reset value
`define OFDFEC_CTRL_RST   32'h00000000
`define OFDFEC_CTRL_MASK  32'h00000337
`define OFDFEC_F_RATE     2:0
`define OFDFEC_F_MOD      5:4
`define OFDFEC_F_ISEL     9:8

// code rate selections
`define OFDFEC_RATE_1_2   3'h0
`define OFDFEC_RATE_2_3   3'h1
`define OFDFEC_RATE_3_4   3'h2
`define OFDFEC_RATE_5_6   3'h3
`define OFDFEC_RATE_7_12  3'h4

// modulation selections
`define OFDFEC_MOD_QPSK   2'h0
`define OFDFEC_MOD_16QAM  2'h1
`define OFDFEC_MOD_64QAM  2'h2

// outer code
`define OFDFEC_RS_LASTMSG 8'hf4
`define OFDFEC_RS_LASTPAR 4'h9
`define OFDFEC_GF_POLY    8'h1d
`define OFDFEC_GF_ALPHA   8'h02

// inner code
`define OFDFEC_CC_GA      7'h5b
`define OFDFEC_CC_GB      7'h79
`define OFDFEC_TAIL_BITS  3'h6

// coded bits per symbol
`define OFDFEC_CBPS_QPSK  10'h0c4
`define OFDFEC_CBPS_16QAM 10'h188
`define OFDFEC_CBPS_64QAM 10'h24c

// interleaver columns and rows at 196 bits per symbol
`define OFDFEC_NCOL_0     5'h04
`define OFDFEC_NCOL_1     5'h07
`define OFDFEC_NCOL_2     5'h0e
`define OFDFEC_NCOL_3     5'h1c
`define OFDFEC_ROW_0      8'h31
`define OFDFEC_ROW_1      8'h1c
`define OFDFEC_ROW_2      8'h0e
`define OFDFEC_ROW_3      8'h07

// pad scrambler defaults
`define OFDFEC_SCR_SEED   9'h1ff
`define OFDFEC_SCR_TAPS   9'h110

`endif

// ### design/ofdfec_ilv.v
module ofdfec_ilv #(
    parameter W    = 1,
    parameter MAXN = 588,
    parameter DIR  = 0
) (
    input  wire         clk_sys,
    input  wire         nrst,
    input  wire [9:0]   ncbps,
    input  wire [7:0]   rowlen,
    input  wire [4:0]   ncol,
    input  wire [1:0]   s_val,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);

    reg [W-1:0] mem [0:MAXN-1];
    reg         fill_ff;
    reg [9:0]   cnt_ff;
    reg [4:0]   kmod_ff;
    reg [7:0]   kdiv_ff;
    reg [9:0]   pi_ff;
    reg         ov_ff;
    reg [W-1:0] od_ff;

    function [1:0] mod_s(input [9:0] v, input [1:0] sm);
        reg [9:0] t;
        begin
            t = v % 10'h003;
            case (sm)
                2'h2:    mod_s = {1'b0, v[0]};
                2'h3:    mod_s = t[1:0];
                default: mod_s = 2'h0;
            endcase
        end
    endfunction

    // first permutation tracked incrementally: pi = rowlen*(k mod ncol) + k/ncol
    wire [1:0] im   = mod_s(pi_ff, s_val);
    wire [1:0] km   = mod_s({5'h00, kmod_ff}, s_val);
    wire [2:0] dsum = {1'b0, im} + {1'b0, s_val} - {1'b0, km};
    wire [1:0] dm   = mod_s({7'h00, dsum}, s_val);
    wire [9:0] pj   = pi_ff - {8'h00, im} + {8'h00, dm};

    wire out_free = !ov_ff | out_ready;
    wire in_go    = in_valid & fill_ff;
    wire out_go   = !fill_ff & out_free & (cnt_ff != ncbps);
    wire step     = (DIR == 0) ? in_go : out_go;
    wire last     = cnt_ff == (ncbps - 10'h001);

    assign in_ready  = fill_ff;
    assign out_valid = ov_ff;
    assign out_data  = od_ff;

    always @(posedge clk_sys) begin
        if (in_go) begin
            mem[(DIR == 0) ? pj : cnt_ff] <= in_data;
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            fill_ff <= 1'b1;
            cnt_ff  <= 10'h000;
            kmod_ff <= 5'h00;
            kdiv_ff <= 8'h00;
            pi_ff   <= 10'h000;
            ov_ff   <= 1'b0;
            od_ff   <= {W{1'b0}};
        end else begin
            if (in_go) begin
                cnt_ff  <= last ? 10'h000 : cnt_ff + 10'h001;
                fill_ff <= !last;
            end
            if (out_go) begin
                ov_ff  <= 1'b1;
                od_ff  <= mem[(DIR == 0) ? cnt_ff : pj];
                cnt_ff <= cnt_ff + 10'h001;
            end else if (!fill_ff && cnt_ff == ncbps && out_free) begin
                ov_ff   <= 1'b0;
                fill_ff <= 1'b1;
                cnt_ff  <= 10'h000;
            end else if (out_ready) begin
                ov_ff <= 1'b0;
            end
            if (step) begin
                if (last) begin
                    kmod_ff <= 5'h00;
                    kdiv_ff <= 8'h00;
                    pi_ff   <= 10'h000;
                end else if (kmod_ff == ncol - 5'h01) begin
                    kmod_ff <= 5'h00;
                    kdiv_ff <= kdiv_ff + 8'h01;
                    pi_ff   <= {2'h0, kdiv_ff + 8'h01};
                end else begin
                    kmod_ff <= kmod_ff + 5'h01;
                    pi_ff   <= pi_ff + {2'h0, rowlen};
                end
            end
        end
    end

endmodule

// ### design/ofdfec_core.v
// Design decisions made here: the register offsets and the plain strobed port.
`include "ofdfec_map.vh"

module ofdfec_core #(
    parameter       SW       = 4,
    parameter       MAX_CBPS = 588,
    parameter [8:0] SCR_SEED = `OFDFEC_SCR_SEED,
    parameter [8:0] SCR_TAPS = `OFDFEC_SCR_TAPS
) (
    input  wire          clk_sys,
    input  wire          nrst,
    input  wire [3:0]    reg_addr,
    input  wire [31:0]   reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output wire [31:0]   reg_rdata,
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [7:0]    in_octet,
    input  wire          in_first,
    input  wire          in_last,
    input  wire          in_hdr,
    output wire          out_valid,
    input  wire          out_ready,
    output wire          out_bit,
    input  wire          rx_valid,
    output wire          rx_ready,
    input  wire [SW-1:0] rx_soft,
    input  wire          rx_restart,
    output wire          dec_valid,
    input  wire          dec_ready,
    output wire [SW-1:0] dec_soft
);

    localparam RS_MSG = 1'b0;
    localparam RS_PAR = 1'b1;

    function [7:0] gf_mul(input [7:0] a, input [7:0] b);
        reg [7:0] p;
        reg [7:0] x;
        integer   n;
        begin
            p = 8'h00;
            x = a;
            for (n = 0; n < 8; n = n + 1) begin
                if (b[n]) begin
                    p = p ^ x;
                end
                x = x[7] ? ({x[6:0], 1'b0} ^ `OFDFEC_GF_POLY) : {x[6:0], 1'b0};
            end
            gf_mul = p;
        end
    endfunction

    // product of (x + alpha^i), i = 1..10, evaluated at elaboration
    function [7:0] gen_coef(input integer idx);
        reg [87:0] p;
        reg [7:0]  r;
        integer    i;
        integer    j;
        begin
            p = 88'h1;
            r = `OFDFEC_GF_ALPHA;
            for (i = 1; i <= 10; i = i + 1) begin
                for (j = 10; j >= 1; j = j - 1) begin
                    p[j*8 +: 8] = p[(j-1)*8 +: 8] ^ gf_mul(p[j*8 +: 8], r);
                end
                p[7:0] = gf_mul(p[7:0], r);
                r = gf_mul(r, `OFDFEC_GF_ALPHA);
            end
            gen_coef = p[idx*8 +: 8];
        end
    endfunction

    function keep_bit(input [2:0] rate, input [2:0] ph, input b);
        begin
            case (rate)
                `OFDFEC_RATE_2_3:  keep_bit = !b | (ph == 3'h0);
                `OFDFEC_RATE_3_4:  keep_bit = (ph == 3'h0) | ((ph == 3'h1) & !b) | ((ph == 3'h2) & b);
                `OFDFEC_RATE_5_6:  keep_bit = (ph == 3'h0) | (ph[0] ? !b : b);
                `OFDFEC_RATE_7_12: keep_bit = (ph < 3'h5) | !b;
                default:           keep_bit = 1'b1;
            endcase
        end
    endfunction

    function [2:0] period_last(input [2:0] rate);
        begin
            case (rate)
                `OFDFEC_RATE_2_3:  period_last = 3'h1;
                `OFDFEC_RATE_3_4:  period_last = 3'h2;
                `OFDFEC_RATE_5_6:  period_last = 3'h4;
                `OFDFEC_RATE_7_12: period_last = 3'h6;
                default:           period_last = 3'h0;
            endcase
        end
    endfunction

    // configuration
    reg  [31:0] ctrl_ff;
    reg  [31:0] rdata_ff;
    reg  [31:0] nxt_rdata;
    reg  [15:0] sym_ff;
    reg  [9:0]  padc_ff;
    wire [2:0]  rate = ctrl_ff[`OFDFEC_F_RATE];
    wire [1:0]  modu = ctrl_ff[`OFDFEC_F_MOD];
    wire [1:0]  isel = ctrl_ff[`OFDFEC_F_ISEL];
    wire [1:0]  s_val = (modu == `OFDFEC_MOD_16QAM) ? 2'h2 :
                        (modu == `OFDFEC_MOD_64QAM) ? 2'h3 : 2'h1;
    wire [9:0]  ncbps = (s_val == 2'h2) ? `OFDFEC_CBPS_16QAM :
                        (s_val == 2'h3) ? `OFDFEC_CBPS_64QAM : `OFDFEC_CBPS_QPSK;
    wire [4:0]  ncol  = (isel == 2'h1) ? `OFDFEC_NCOL_1 :
                        (isel == 2'h2) ? `OFDFEC_NCOL_2 :
                        (isel == 2'h3) ? `OFDFEC_NCOL_3 : `OFDFEC_NCOL_0;
    wire [7:0]  rbase = (isel == 2'h1) ? `OFDFEC_ROW_1 :
                        (isel == 2'h2) ? `OFDFEC_ROW_2 :
                        (isel == 2'h3) ? `OFDFEC_ROW_3 : `OFDFEC_ROW_0;
    wire [7:0]  rowlen = (s_val == 2'h1) ? rbase :
                         (s_val == 2'h2) ? {rbase[6:0], 1'b0} : rbase + {rbase[6:0], 1'b0};

    // outer encoder state
    reg         rs_st_ff;
    reg  [7:0]  rs_cnt_ff;
    reg  [3:0]  rs_pidx_ff;
    reg         rs_plast_ff;
    reg  [79:0] par_ff;
    wire [79:0] nxt_par;
    reg         oq_v_ff;
    reg  [7:0]  oq_d_ff;
    reg         oq_first_ff;
    reg         oq_last_ff;
    reg         oq_hdr_ff;

    // serializer, inner encoder, puncturer, pad
    reg  [7:0]  sh_d_ff;
    reg  [3:0]  sh_n_ff;
    reg         sh_first_ff;
    reg         sh_end_ff;
    reg         sh_pay_ff;
    reg  [2:0]  tail_n_ff;
    reg  [5:0]  sr_ff;
    reg  [2:0]  ph_ff;
    reg         pa_ff;
    reg         pb_ff;
    reg         pend_a_ff;
    reg         pend_b_ff;
    reg         p_end_ff;
    reg         pad_act_ff;
    reg  [9:0]  pad_n_ff;
    reg  [8:0]  lfsr_ff;
    reg  [9:0]  blk_ff;

    // receive depuncturer
    reg  [2:0]    r_ph_ff;
    reg           r_slot_ff;
    reg           dec_v_ff;
    reg  [SW-1:0] dec_d_ff;
    wire          dq_v;
    wire          dq_ready;
    wire [SW-1:0] dq_d;

    wire oq_take = oq_v_ff & (sh_n_ff == 4'h0) & (tail_n_ff == 3'h0);
    wire oq_free = !oq_v_ff | oq_take;
    wire in_go   = in_valid & in_ready;
    wire msg_go  = in_go & !in_hdr;
    wire par_go  = (rs_st_ff == RS_PAR) & oq_free;
    wire [7:0] rs_fb = msg_go ? (in_octet ^ par_ff[79:72]) : 8'h00;

    assign in_ready = (rs_st_ff == RS_MSG) & oq_free;

    // parity register; zero feedback during readout turns it into a shifter
    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : gen_par
            localparam [7:0] GC = gen_coef(g);
            wire [7:0] lower;
            if (g == 0) begin : gen_lo0
                assign lower = 8'h00;
            end else begin : gen_lon
                assign lower = par_ff[g*8-1 -: 8];
            end
            assign nxt_par[g*8 +: 8] = lower ^ gf_mul(rs_fb, GC);
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (!nrst) begin
            rs_st_ff    <= RS_MSG;
            rs_cnt_ff   <= 8'h00;
            rs_pidx_ff  <= 4'h0;
            rs_plast_ff <= 1'b0;
            par_ff      <= 80'h0;
            oq_v_ff     <= 1'b0;
            oq_d_ff     <= 8'h00;
            oq_first_ff <= 1'b0;
            oq_last_ff  <= 1'b0;
            oq_hdr_ff   <= 1'b0;
        end else begin
            if (msg_go | par_go) begin
                par_ff <= nxt_par;
            end
            if (in_go) begin
                oq_v_ff     <= 1'b1;
                oq_d_ff     <= in_octet;
                oq_first_ff <= in_first;
                oq_hdr_ff   <= in_hdr;
                oq_last_ff  <= in_hdr & in_last;
                if (msg_go) begin
                    if (in_last || rs_cnt_ff == `OFDFEC_RS_LASTMSG) begin
                        rs_st_ff    <= RS_PAR;
                        rs_pidx_ff  <= 4'h0;
                        rs_plast_ff <= in_last;
                        rs_cnt_ff   <= 8'h00;
                    end else begin
                        rs_cnt_ff <= rs_cnt_ff + 8'h01;
                    end
                end
            end else if (par_go) begin
                oq_v_ff     <= 1'b1;
                oq_d_ff     <= par_ff[79:72];
                oq_first_ff <= 1'b0;
                oq_hdr_ff   <= 1'b0;
                oq_last_ff  <= rs_plast_ff & (rs_pidx_ff == `OFDFEC_RS_LASTPAR);
                rs_pidx_ff  <= rs_pidx_ff + 4'h1;
                if (rs_pidx_ff == `OFDFEC_RS_LASTPAR) begin
                    rs_st_ff <= RS_MSG;
                end
            end else if (oq_take) begin
                oq_v_ff <= 1'b0;
            end
        end
    end

    // inner encoder input: serialized octet bits, then tail zeros
    wire       src_tail  = tail_n_ff != 3'h0;
    wire       src_v     = src_tail | (sh_n_ff != 4'h0);
    wire       src_bit   = src_tail ? 1'b0 : sh_d_ff[0];
    wire       src_first = !src_tail & sh_first_ff;
    wire       p_free    = !(pend_a_ff | pend_b_ff);
    wire       cc_go     = src_v & p_free & !pad_act_ff & !p_end_ff;
    wire [5:0] sr_use    = src_first ? 6'h00 : sr_ff;
    wire [2:0] ph_use    = src_first ? 3'h0 : ph_ff;
    wire [6:0] cc_vec    = {src_bit, sr_use[0], sr_use[1], sr_use[2], sr_use[3], sr_use[4], sr_use[5]};
    wire       cc_a      = ^(cc_vec & `OFDFEC_CC_GA);
    wire       cc_b      = ^(cc_vec & `OFDFEC_CC_GB);
    wire       pad_bit   = ^(lfsr_ff & SCR_TAPS);
    wire       cb_v      = pend_a_ff | pend_b_ff;
    wire       cb        = pend_a_ff ? pa_ff : pb_ff;
    wire       il_v      = pad_act_ff | cb_v;
    wire       il_d      = pad_act_ff ? pad_bit : cb;
    wire       il_ready;
    wire       il_go     = il_v & il_ready;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            sh_d_ff     <= 8'h00;
            sh_n_ff     <= 4'h0;
            sh_first_ff <= 1'b0;
            sh_end_ff   <= 1'b0;
            sh_pay_ff   <= 1'b0;
            tail_n_ff   <= 3'h0;
            sr_ff       <= 6'h00;
            ph_ff       <= 3'h0;
            pa_ff       <= 1'b0;
            pb_ff       <= 1'b0;
            pend_a_ff   <= 1'b0;
            pend_b_ff   <= 1'b0;
            p_end_ff    <= 1'b0;
            pad_act_ff  <= 1'b0;
            pad_n_ff    <= 10'h000;
            lfsr_ff     <= SCR_SEED;
            blk_ff      <= 10'h000;
            sym_ff      <= 16'h0000;
            padc_ff     <= 10'h000;
        end else begin
            if (oq_take) begin
                sh_d_ff     <= oq_d_ff;
                sh_n_ff     <= 4'h8;
                sh_first_ff <= oq_first_ff;
                sh_end_ff   <= oq_last_ff;
                sh_pay_ff   <= !oq_hdr_ff;
            end
            if (cc_go) begin
                sr_ff     <= {sr_use[4:0], src_bit};
                ph_ff     <= (ph_use == period_last(rate)) ? 3'h0 : ph_use + 3'h1;
                pa_ff     <= cc_a;
                pb_ff     <= cc_b;
                pend_a_ff <= keep_bit(rate, ph_use, 1'b0);
                pend_b_ff <= keep_bit(rate, ph_use, 1'b1);
                if (src_tail) begin
                    tail_n_ff <= tail_n_ff - 3'h1;
                    p_end_ff  <= tail_n_ff == 3'h1;
                end else begin
                    sh_d_ff     <= {1'b0, sh_d_ff[7:1]};
                    sh_n_ff     <= sh_n_ff - 4'h1;
                    sh_first_ff <= 1'b0;
                    if (sh_n_ff == 4'h1 && sh_end_ff && sh_pay_ff) begin
                        tail_n_ff <= `OFDFEC_TAIL_BITS;
                    end
                end
                if (src_first && !sh_pay_ff) begin
                    sym_ff <= 16'h0000;
                end
            end else if (il_go && !pad_act_ff) begin
                if (pend_a_ff) begin
                    pend_a_ff <= 1'b0;
                end else begin
                    pend_b_ff <= 1'b0;
                end
            end
            // once the tail has drained, fill out the open symbol
            if (p_end_ff && p_free && !cc_go) begin
                p_end_ff   <= 1'b0;
                pad_act_ff <= blk_ff != 10'h000;
                pad_n_ff   <= ncbps - blk_ff;
                padc_ff    <= (blk_ff == 10'h000) ? 10'h000 : ncbps - blk_ff;
                lfsr_ff    <= SCR_SEED;
            end
            if (il_go) begin
                blk_ff <= (blk_ff == ncbps - 10'h001) ? 10'h000 : blk_ff + 10'h001;
                if (blk_ff == 10'h000) begin
                    sym_ff <= sym_ff + 16'h0001;
                end
                if (pad_act_ff) begin
                    lfsr_ff  <= {lfsr_ff[7:0], pad_bit};
                    pad_n_ff <= pad_n_ff - 10'h001;
                    if (pad_n_ff == 10'h001) begin
                        pad_act_ff <= 1'b0;
                    end
                end
            end
        end
    end

    ofdfec_ilv #(
        .W    (1),
        .MAXN (MAX_CBPS),
        .DIR  (0)
    ) u_tx_ilv (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .ncbps     (ncbps),
        .rowlen    (rowlen),
        .ncol      (ncol),
        .s_val     (s_val),
        .in_valid  (il_v),
        .in_ready  (il_ready),
        .in_data   (il_d),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_bit)
    );

    ofdfec_ilv #(
        .W    (SW),
        .MAXN (MAX_CBPS),
        .DIR  (1)
    ) u_rx_ilv (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .ncbps     (ncbps),
        .rowlen    (rowlen),
        .ncol      (ncol),
        .s_val     (s_val),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_soft),
        .out_valid (dq_v),
        .out_ready (dq_ready),
        .out_data  (dq_d)
    );

    // depuncturer: a dropped slot is filled with zero without waiting for input
    wire dp_keep = keep_bit(rate, r_ph_ff, r_slot_ff);
    wire dp_free = !dec_v_ff | dec_ready;
    wire dp_go   = dp_free & (!dp_keep | dq_v);

    assign dq_ready  = dp_free & dp_keep;
    assign dec_valid = dec_v_ff;
    assign dec_soft  = dec_d_ff;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            r_ph_ff   <= 3'h0;
            r_slot_ff <= 1'b0;
            dec_v_ff  <= 1'b0;
            dec_d_ff  <= {SW{1'b0}};
        end else begin
            if (dp_go) begin
                dec_v_ff <= 1'b1;
                dec_d_ff <= dp_keep ? dq_d : {SW{1'b0}};
            end else if (dec_ready) begin
                dec_v_ff <= 1'b0;
            end
            if (rx_restart) begin
                r_ph_ff   <= 3'h0;
                r_slot_ff <= 1'b0;
            end else if (dp_go) begin
                r_slot_ff <= !r_slot_ff;
                if (r_slot_ff) begin
                    r_ph_ff <= (r_ph_ff == period_last(rate)) ? 3'h0 : r_ph_ff + 3'h1;
                end
            end
        end
    end

    // register port
    always @* begin
        case (reg_addr)
            `OFDFEC_REG_CTRL: nxt_rdata = ctrl_ff;
            `OFDFEC_REG_SYMS: nxt_rdata = {16'h0000, sym_ff};
            `OFDFEC_REG_PAD:  nxt_rdata = {22'h000000, padc_ff};
            default:          nxt_rdata = 32'h00000000;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_ff  <= `OFDFEC_CTRL_RST;
            rdata_ff <= 32'h00000000;
        end else begin
            if (reg_wr && reg_addr == `OFDFEC_REG_CTRL) begin
                ctrl_ff <= reg_wdata & `OFDFEC_CTRL_MASK;
            end
            rdata_ff <= reg_rd ? nxt_rdata : 32'h00000000;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule

// ### tb/ofdfec_chk_monitor.sv
module ofdfec_chk #(parameter SW = 4) (
    input wire          clk_sys,
    input wire          nrst,
    input wire [3:0]    reg_addr,
    input wire          reg_rd,
    input wire [31:0]   reg_rdata,
    input wire          in_ready,
    input wire          rx_ready,
    input wire          out_valid,
    input wire          out_ready,
    input wire          out_bit,
    input wire          dec_valid,
    input wire          dec_ready,
    input wire [SW-1:0] dec_soft
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_rst; $rose(nrst) |-> in_ready && rx_ready && !out_valid && !dec_valid; endproperty
    a_rst: assert property (p_rst) else $error("state after reset wrong");
    property p_ohold; out_valid && !out_ready |=> out_valid && $stable(out_bit); endproperty
    a_ohold: assert property (p_ohold) else $error("coded bit not held");
    property p_dhold; dec_valid && !dec_ready |=> dec_valid && $stable(dec_soft); endproperty
    a_dhold: assert property (p_dhold) else $error("soft value not held");
    property p_ctrl; reg_rd && reg_addr == 4'h0 |=> (reg_rdata & ~32'h00000337) == 32'h0; endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl reserved bits set");
    property p_unm; reg_rd && reg_addr != 4'h0 && reg_addr != 4'h4 && reg_addr != 4'h8 |=> reg_rdata == 32'h0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_syms; reg_rd && reg_addr == 4'h4 |=> reg_rdata[31:16] == 16'h0; endproperty
    a_syms: assert property (p_syms) else $error("symbol count too wide");
    property p_pad; reg_rd && reg_addr == 4'h8 |=> reg_rdata < 32'h0000024c; endproperty
    a_pad: assert property (p_pad) else $error("pad count not below block");
    property p_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside slot");
endmodule
bind ofdfec_core ofdfec_chk #(.SW(SW)) u_chk (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_ready(in_ready), .rx_ready(rx_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_bit(out_bit), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_soft(dec_soft));

// ### tb/ofdfec_sink.sv
module ofdfec_sink #(parameter SW = 4) (
    input  wire          clk_sys,
    input  wire          out_valid,
    input  wire          dec_valid,
    input  wire [SW-1:0] dec_soft,
    output logic         out_ready,
    output logic         dec_ready,
    output int           out_cnt_ff,
    output int           zero_cnt_ff,
    output int           val_cnt_ff,
    output int           val_sum_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ph_ff = 3'h0;
    initial begin
        out_ready = 1'b0;
        dec_ready = 1'b0;
        out_cnt_ff = 0;
        zero_cnt_ff = 0;
        val_cnt_ff = 0;
        val_sum_ff = 0;
    end
    // mapper and decoder stall on a fixed pattern
    always @(posedge clk_sys) begin
        ph_ff <= ph_ff + 3'h1;
        out_ready <= ph_ff[0] | ph_ff[2];
        dec_ready <= ph_ff[1] | ph_ff[0];
        if (out_valid && out_ready) out_cnt_ff <= out_cnt_ff + 1;
        if (dec_valid && dec_ready && dec_soft === '0) zero_cnt_ff <= zero_cnt_ff + 1;
        // position-weighted sum exposes the order of delivered values
        if (dec_valid && dec_ready && dec_soft !== '0) begin
            val_cnt_ff <= val_cnt_ff + 1;
            val_sum_ff <= val_sum_ff + val_cnt_ff * dec_soft;
        end
    end
endmodule

// ### tb/test_ofdm_fec_encode_interleave.sv
module test_ofdm_fec_encode_interleave;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, in_valid = 0, in_first = 0, in_last = 0;
    logic        in_hdr = 0, rx_valid = 0, rx_restart = 0;
    logic [3:0]  reg_addr = 4'h0, rx_soft = 4'h1;
    logic [7:0]  in_octet = 8'h0;
    logic [31:0] reg_wdata = 32'h0, rd_q, s0;
    wire         in_ready, out_valid, out_ready, out_bit, rx_ready, dec_valid, dec_ready;
    wire  [31:0] reg_rdata;
    wire  [3:0]  dec_soft;
    int          bad_count = 0, cmp_count = 0, n_out, n_z, n_nz, b0, z0, m, k, t, ws, e;
    int rt[8] = '{0, 1, 2, 3, 4, 0, 0, 0};
    int md[8] = '{0, 0, 0, 0, 0, 1, 2, 0};
    int sy[8] = '{2, 1, 1, 1, 1, 1, 1, 2};
    int pd[8] = '{188, 43, 60, 73, 20, 188, 384, 172};
    int cb[8] = '{196, 196, 196, 196, 196, 392, 588, 196};
    ofdfec_core dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready),
        .in_octet(in_octet), .in_first(in_first), .in_last(in_last), .in_hdr(in_hdr), .out_valid(out_valid),
        .out_ready(out_ready), .out_bit(out_bit), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_soft(rx_soft),
        .rx_restart(rx_restart), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_soft(dec_soft));
    ofdfec_sink u_sink (.clk_sys(clk_sys), .out_valid(out_valid), .dec_valid(dec_valid), .dec_soft(dec_soft),
        .out_ready(out_ready), .dec_ready(dec_ready), .out_cnt_ff(n_out), .zero_cnt_ff(n_z), .val_cnt_ff(n_nz),
        .val_sum_ff(ws));
    initial forever #50 clk_sys = ~clk_sys;
    task results;
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask
    // ready is sampled at the falling edge; state only moves on rising edges
    task put(input logic [7:0] o, input logic f, input logic l);
        @(posedge clk_sys);
        in_valid <= 1'b1; in_octet <= o; in_first <= f; in_last <= l;
        for (t = 0; t < 3000; t++) begin
            @(negedge clk_sys);
            if (in_ready) break;
        end
        @(posedge clk_sys);
        in_valid <= 1'b0;
    endtask
    initial begin #5000000; bad_count++; results; end
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(4'h0); chk("ctrl", 32'h0, rd_q);
        wr(4'h0, 32'hffffffff); rd(4'h0); chk("ctrl", 32'h00000337, rd_q);
        wr(4'h4, 32'h00001234); rd(4'hc); chk("unmapped", 32'h0, rd_q);
        rd(4'h4); chk("syms", 32'h0, rd_q);
        for (m = 0; m < 8; m++) begin
            wr(4'h0, {22'h0, m[1:0], 2'h0, md[m][1:0], 1'b0, rt[m][2:0]});
            rd(4'h4); s0 = rd_q; b0 = n_out;
            // last mode: a one-octet header ahead of the payload
            if (m == 7) begin
                in_hdr <= 1'b1;
                put(8'h5a, 1'b1, 1'b1);
                in_hdr <= 1'b0;
            end
            put(8'ha5, 1'b1, 1'b0); put(8'h3c, 1'b0, 1'b1);
            for (t = 0; t < 20000 && n_out - b0 < sy[m] * cb[m]; t++) @(posedge clk_sys);
            repeat (60) @(posedge clk_sys);
            chk("bits", sy[m] * cb[m], n_out - b0);
            rd(4'h4); chk("syms", (m == 7 ? 0 : s0) + sy[m], rd_q);
            rd(4'h8); chk("pad", pd[m], rd_q);
        end
        wr(4'h0, 32'h00000002);
        @(posedge clk_sys); rx_restart <= 1'b1;
        @(posedge clk_sys); rx_restart <= 1'b0; rx_valid <= 1'b1; z0 = n_z; b0 = n_nz;
        for (k = 0, t = 0; k < 196 && t < 5000; t++) begin
            @(negedge clk_sys);
            if (rx_ready) k++;
            @(posedge clk_sys);
            rx_soft <= 4'h1 + {1'b0, k[2:0]};
        end
        rx_valid <= 1'b0;
        for (t = 0; t < 5000 && n_nz - b0 < 196; t++) @(posedge clk_sys);
        repeat (60) @(posedge clk_sys);
        chk("soft", 196, n_nz - b0);
        chk("zeros", 98, n_z - z0);
        for (k = 0, e = 0; k < 196; k++) e += k * (1 + (49 * (k % 4) + k / 4) % 8);
        chk("order", e, ws);
        results;
    end
endmodule
